// [hdl/mac_table_scan_and_dest_lookup.sv]
`timescale 1ns/1ps
module mac_table_scan_and_dest_lookup
    import mac_scan_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // Wishbone slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [7:0]        wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    // Table loader and port group table write
    input  wire logic              load_en_in,
    input  wire logic [ROW_W-1:0]  load_row_in,
    input  wire mac_entry_s        load_entry_in,
    input  wire logic              pgid_we_in,
    input  wire logic [PGID_W-1:0] pgid_idx_in,
    input  wire logic [PORT_W-1:0] pgid_mask_in,
    // Forwarding lookup
    input  wire fwd_req_s          fwd_req_in,
    output fwd_res_s               fwd_res_out
);
    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    mac_entry_s        table_mem [ROWS];
    logic [PORT_W-1:0] pgid_mem  [1<<PGID_W];

    // ---------------------------------------------------------------
    // Software registers and scan state
    // ---------------------------------------------------------------
    logic [31:0] access_ctrl, next_access_ctrl;
    logic [31:0] scan_cfg, next_scan_cfg;
    logic [31:0] entry_cfg, next_entry_cfg;
    logic [31:0] move_cfg, next_move_cfg;
    logic [31:0] fwd_cfg, next_fwd_cfg;
    logic [ROW_W-1:0] last_pos, next_last_pos;
    logic [15:0] match_cnt, next_match_cnt;
    logic [1:0]  events, next_events;
    logic [31:0] wb_dat_out_r, next_wb_dat;
    logic        ack_r, next_ack;
    scan_state_e state, next_state;
    logic [ROW_W-1:0] row, next_row;
    mac_entry_s  cur, next_cur;

    logic        wr_en;
    logic [ROW_W-1:0] wr_row;
    mac_entry_s  wr_entry;

    wire logic req = wb_cyc_in & wb_stb_in & ~ack_r;
    wire logic busy = access_ctrl[TRIG_BIT];

    // Byte-lane write merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Match evaluation on the row just read
    // ---------------------------------------------------------------
    logic [ADDR_W-1:0] amask, new_addr, cfg_addr;
    logic [FID_W-1:0]  cfg_fid;
    logic [KIND_W-1:0] cfg_kind;
    logic [AGE_W-1:0]  max_age;
    logic              hit;
    always_comb begin
        amask    = move_cfg[MC_MASK +: ADDR_W];
        new_addr = move_cfg[MC_NEW +: ADDR_W];
        cfg_addr = entry_cfg[EC_ADDR +: ADDR_W];
        cfg_fid  = entry_cfg[EC_FID +: FID_W];
        cfg_kind = entry_cfg[EC_KIND +: KIND_W];
        max_age  = scan_cfg[SC_MAXAGE +: AGE_W];
        hit = cur.valid;
        if (scan_cfg[SC_FIDF] && cur.fid != cfg_fid) begin
            hit = 1'b0;
        end
        if (scan_cfg[SC_ADDRF] &&
            (cur.kind != cfg_kind || (cur.addr & amask) != (cfg_addr & amask))) begin
            hit = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Register file and scan sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_access_ctrl = access_ctrl;
        next_scan_cfg    = scan_cfg;
        next_entry_cfg   = entry_cfg;
        next_move_cfg    = move_cfg;
        next_fwd_cfg     = fwd_cfg;
        next_last_pos    = last_pos;
        next_match_cnt   = match_cnt;
        next_events      = events;
        next_state       = state;
        next_row         = row;
        next_cur         = cur;
        next_ack         = req;
        next_wb_dat      = RST_ZERO;
        wr_en            = 1'b0;
        wr_row           = row;
        wr_entry         = cur;

        // Bus reads; unmapped addresses read zero and still ack
        if (req && !wb_we_in) begin
            case (wb_adr_in)
                OFS_ACCESS_CTRL: next_wb_dat = access_ctrl;
                OFS_SCAN_CFG:    next_wb_dat = scan_cfg;
                OFS_ENTRY_CFG:   next_wb_dat = entry_cfg;
                OFS_MOVE_CFG:    next_wb_dat = move_cfg;
                OFS_POS_STATUS:  next_wb_dat = {{(32-ROW_W){1'b0}}, last_pos};
                OFS_MATCH_CNT:   next_wb_dat = {16'h0000, match_cnt};
                OFS_EVENTS:      next_wb_dat = {30'h0000_0000, events};
                OFS_FWD_CFG:     next_wb_dat = fwd_cfg;
                default:         next_wb_dat = RST_ZERO;
            endcase
        end

        // Config writes; access, scan, entry and move config changes are held off while a scan runs, fwd_cfg is not
        if (req && wb_we_in) begin
            case (wb_adr_in)
                OFS_ACCESS_CTRL: begin
                    if (!busy) begin
                        next_access_ctrl = merge(access_ctrl, wb_dat_in, wb_sel_in);
                    end
                end
                OFS_SCAN_CFG:  if (!busy) next_scan_cfg = merge(scan_cfg, wb_dat_in, wb_sel_in);
                OFS_ENTRY_CFG: if (!busy) next_entry_cfg = merge(entry_cfg, wb_dat_in, wb_sel_in);
                OFS_MOVE_CFG:  if (!busy) next_move_cfg = merge(move_cfg, wb_dat_in, wb_sel_in);
                OFS_FWD_CFG:   next_fwd_cfg = merge(fwd_cfg, wb_dat_in, wb_sel_in);
                OFS_EVENTS: begin
                    // Write one to clear
                    if (wb_sel_in[0]) begin
                        next_events = events & ~wb_dat_in[1:0];
                    end
                end
                default: ;
            endcase
        end

        case (state)
            S_IDLE: begin
                if (busy) begin
                    if (access_ctrl[CMD_LSB +: 4] == CMD_SCAN) begin
                        next_row       = access_ctrl[ROW_LSB +: ROW_W];
                        next_match_cnt = 16'h0000;
                        next_state     = S_READ;
                    end else begin
                        next_access_ctrl[TRIG_BIT] = 1'b0; // Other commands live elsewhere
                    end
                end
            end
            S_READ: begin
                next_cur   = table_mem[row];
                next_state = S_WRITE;
            end
            S_WRITE: begin
                next_state = S_READ;
                if (hit) begin
                    next_last_pos  = row;
                    next_match_cnt = match_cnt + 16'h0001;
                    next_events[EV_FOUND] = 1'b1;
                    wr_en = 1'b1;
                    if (scan_cfg[SC_AGEUPD]) begin
                        wr_entry.age = scan_cfg[SC_AGEVAL +: AGE_W];
                    end
                    if (scan_cfg[SC_LRNUPD]) begin
                        wr_entry.learn_all = scan_cfg[SC_LRNVAL];
                    end
                    if (scan_cfg[SC_MOVE]) begin
                        wr_entry.addr = (cur.addr & ~amask) | (new_addr & amask);
                    end
                    if (scan_cfg[SC_SWAGE]) begin
                        if (cur.age == max_age) begin
                            wr_entry.valid = 1'b0;
                        end else if (cur.age < max_age) begin
                            wr_entry.age = cur.age + 1'b1;
                        end
                    end
                    if (scan_cfg[SC_REMOVE]) begin
                        wr_entry.valid = 1'b0;
                        next_events[EV_REMOVED] = 1'b1;
                    end
                end
                // Ascending walk; stop at end or at first hit in find-next
                if (row == ROW_W'(ROWS - 1) || (hit && scan_cfg[SC_STOP])) begin
                    next_access_ctrl[TRIG_BIT] = 1'b0;
                    next_state = S_IDLE;
                end else begin
                    next_row = row + 1'b1;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            access_ctrl  <= RST_ZERO;
            scan_cfg     <= RST_ZERO;
            entry_cfg    <= RST_ZERO;
            move_cfg     <= RST_ZERO;
            fwd_cfg      <= RST_ZERO;
            last_pos     <= '0;
            match_cnt    <= 16'h0000;
            events       <= 2'b00;
            wb_dat_out_r <= RST_ZERO;
            ack_r        <= 1'b0;
            state        <= S_IDLE;
            row          <= '0;
            cur          <= '0;
        end else begin
            access_ctrl  <= next_access_ctrl;
            scan_cfg     <= next_scan_cfg;
            entry_cfg    <= next_entry_cfg;
            move_cfg     <= next_move_cfg;
            fwd_cfg      <= next_fwd_cfg;
            last_pos     <= next_last_pos;
            match_cnt    <= next_match_cnt;
            events       <= next_events;
            wb_dat_out_r <= next_wb_dat;
            ack_r        <= next_ack;
            state        <= next_state;
            row          <= next_row;
            cur          <= next_cur;
        end
    end

    // Table writes; the scan wins over the loader in the same cycle, on any row
    always_ff @(posedge clk_in) begin
        if (wr_en) begin
            table_mem[wr_row] <= wr_entry;
        end else if (load_en_in) begin
            table_mem[load_row_in] <= load_entry_in;
        end
        if (pgid_we_in) begin
            pgid_mem[pgid_idx_in] <= pgid_mask_in;
        end
    end

    assign wb_dat_out = wb_dat_out_r;
    assign wb_ack_out = ack_r;

    // ---------------------------------------------------------------
    // Destination lookup: combinational search, one registered result
    // ---------------------------------------------------------------
    fwd_res_s    next_res, res;
    logic        dhit;
    mac_entry_s  dent;
    logic [PORT_W-1:0] mask;
    logic        skip;
    always_comb begin
        dhit = 1'b0;
        dent = '0;
        // Linear search costs area; a real table would hash the key
        for (int i = 0; i < ROWS; i++) begin
            if (!dhit && table_mem[i].valid && table_mem[i].mac == fwd_req_in.dmac &&
                table_mem[i].fid == fwd_req_in.egress_filtering_identifier) begin
                dhit = 1'b1;
                dent = table_mem[i];
            end
        end
        next_res = '0;
        next_res.valid = fwd_req_in.valid;
        next_res.queue = fwd_cfg[FC_QU +: QU_W];
        if (dhit) begin
            mask = pgid_mem[PGID_W'({dent.kind, dent.addr})];
            skip = dent.skip_vlan;
        end else begin
            mask = fwd_cfg[FC_UNKSRC] ? pgid_mem[fwd_cfg[FC_FLOOD +: PGID_W]] : '0;
            skip = fwd_cfg[FC_SKIPFL];
            // No flood flags on an idle request slot, only on real frames
            next_res.flooded = fwd_req_in.valid & fwd_cfg[FC_UNKSRC];
            next_res.mirror  = next_res.flooded & fwd_cfg[FC_MIRROR];
            next_res.copy    = next_res.flooded & fwd_cfg[FC_COPY];
        end
        if (!(skip && !fwd_cfg[FC_FMODE])) begin
            mask = mask & fwd_req_in.vlan_mask;
        end
        if (!(skip && fwd_cfg[FC_FMODE])) begin
            mask = mask & fwd_req_in.src_mask;
        end
        next_res.ports = fwd_req_in.valid ? mask : '0;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            res <= '0;
        end else begin
            res <= next_res;
        end
    end

    assign fwd_res_out = res;
endmodule

// [inc/mac_scan_pkg.sv]
package mac_scan_pkg;
    // ---------------------------------------------------------------
    // Table geometry
    // ---------------------------------------------------------------
    localparam int ROW_W   = 6;
    localparam int ROWS    = 64;
    localparam int MAC_W   = 48;
    localparam int FID_W   = 13;
    localparam int ADDR_W  = 12;
    localparam int KIND_W  = 2;
    localparam int AGE_W   = 2;
    localparam int PORT_W  = 16;
    localparam int PGID_W  = 6;
    localparam int QU_W    = 3;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_ACCESS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SCAN_CFG    = 8'h04;
    localparam logic [7:0] OFS_ENTRY_CFG   = 8'h08;
    localparam logic [7:0] OFS_MOVE_CFG    = 8'h0C;
    localparam logic [7:0] OFS_POS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_MATCH_CNT   = 8'h14;
    localparam logic [7:0] OFS_EVENTS      = 8'h18;
    localparam logic [7:0] OFS_FWD_CFG     = 8'h1C;

    // Access control fields
    localparam int CMD_LSB     = 0;
    localparam int TRIG_BIT    = 4;
    localparam int ROW_LSB     = 8;
    localparam int TYPE_LSB    = 16;
    localparam logic [3:0] CMD_SCAN = 4'h5;

    // Scan config fields
    localparam int SC_STOP   = 0;
    localparam int SC_AGEUPD = 1;
    localparam int SC_AGEVAL = 2;
    localparam int SC_LRNUPD = 4;
    localparam int SC_LRNVAL = 5;
    localparam int SC_MOVE   = 6;
    localparam int SC_REMOVE = 7;
    localparam int SC_SWAGE  = 8;
    localparam int SC_FIDF   = 9;
    localparam int SC_ADDRF  = 10;
    localparam int SC_MAXAGE = 12;

    // Entry config fields
    localparam int EC_FID  = 0;
    localparam int EC_ADDR = 16;
    localparam int EC_KIND = 28;

    // Move config fields
    localparam int MC_NEW  = 0;
    localparam int MC_MASK = 16;

    // Event bits
    localparam int EV_REMOVED = 0;
    localparam int EV_FOUND   = 1;

    // Forwarding config fields
    localparam int FC_MIRROR = 0;
    localparam int FC_COPY   = 1;
    localparam int FC_SKIPFL = 2;
    localparam int FC_FMODE  = 3;
    localparam int FC_UNKSRC = 4;
    localparam int FC_QU     = 8;
    localparam int FC_FLOOD  = 16;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // Table entry
    typedef struct packed {
        logic              valid;
        logic [MAC_W-1:0]  mac;
        logic [FID_W-1:0]  fid;
        logic [KIND_W-1:0] kind;
        logic [ADDR_W-1:0] addr;
        logic [AGE_W-1:0]  age;
        logic              learn_all;
        logic              skip_vlan;
    } mac_entry_s;

    // Forwarding request and result
    typedef struct packed {
        logic              valid;
        logic [MAC_W-1:0]  dmac;
        logic [FID_W-1:0]  egress_filtering_identifier;
        logic [PORT_W-1:0] vlan_mask;
        logic [PORT_W-1:0] src_mask;
    } fwd_req_s;

    typedef struct packed {
        logic              valid;
        logic              flooded;
        logic              mirror;
        logic              copy;
        logic [QU_W-1:0]   queue;
        logic [PORT_W-1:0] ports;
    } fwd_res_s;

    typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} scan_state_e;
endpackage

// [test/mac_scan_asserts.sv]
`timescale 1ns/1ps
module mac_scan_asserts
    import mac_scan_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Register bus
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic [31:0] wb_dat_out,
    input  wire logic        wb_ack_out,
    // Forwarding lookup
    input  wire fwd_req_s    fwd_req_in,
    input  wire fwd_res_s    fwd_res_out
);
    // ------------------------------------------------------------
    // Shadow of the forwarding config
    // ------------------------------------------------------------
    logic [31:0] fwd_cfg;
    logic [31:0] next_fwd_cfg;

    // Follows the acked write, so it never runs ahead of the real register
    always_comb begin
        next_fwd_cfg = fwd_cfg;
        if (wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_adr_in == OFS_FWD_CFG) begin
            next_fwd_cfg = wb_dat_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fwd_cfg <= RST_ZERO;
        end else begin
            fwd_cfg <= next_fwd_cfg;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence new_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence

    sequence ack_once;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    ack_timely_a: assert property (new_req |=> ack_once)
        else $error("bus ack not a single pulse one cycle after request");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("bus ack without request");
    unmapped_zero_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in &&
        wb_adr_in >= 8'h20 |=> wb_dat_out == RST_ZERO) else $error("unmapped read not zero");
    res_valid_a: assert property (1'b1 |=> fwd_res_out.valid == $past(fwd_req_in.valid))
        else $error("lookup result valid does not follow request");
    flood_gate_a: assert property (fwd_res_out.flooded |-> fwd_res_out.valid && fwd_cfg[FC_UNKSRC])
        else $error("flood without unknown source permission");
    flood_attr_a: assert property (fwd_res_out.flooded |->
        fwd_res_out.mirror == fwd_cfg[FC_MIRROR] && fwd_res_out.copy == fwd_cfg[FC_COPY])
        else $error("flood mirror or copy flag wrong");
    copy_queue_a: assert property (fwd_res_out.copy |-> fwd_res_out.queue == fwd_cfg[FC_QU+:QU_W])
        else $error("copy queue wrong");
    known_plain_a: assert property (fwd_res_out.valid && !fwd_res_out.flooded |->
        !fwd_res_out.mirror && !fwd_res_out.copy) else $error("unflooded frame mirrored or copied");
endmodule

bind mac_table_scan_and_dest_lookup mac_scan_asserts i_chk (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .wb_cyc_in   (wb_cyc_in),
    .wb_stb_in   (wb_stb_in),
    .wb_we_in    (wb_we_in),
    .wb_adr_in   (wb_adr_in),
    .wb_dat_in   (wb_dat_in),
    .wb_dat_out  (wb_dat_out),
    .wb_ack_out  (wb_ack_out),
    .fwd_req_in  (fwd_req_in),
    .fwd_res_out (fwd_res_out)
);

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import mac_scan_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    logic clk, rst, cyc, stb, we, ack, load_en, pg_we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [ROW_W-1:0] load_row;
    logic [PGID_W-1:0] pg_idx;
    logic [PORT_W-1:0] pg_mask;
    mac_entry_s load_entry;
    fwd_req_s req;
    fwd_res_s res;
    int fail_count, compares, cycles;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    mac_table_scan_and_dest_lookup i_dut (.clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .load_en_in(load_en), .load_row_in(load_row),
        .load_entry_in(load_entry), .pgid_we_in(pg_we), .pgid_idx_in(pg_idx),
        .pgid_mask_in(pg_mask), .fwd_req_in(req), .fwd_res_out(res));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_res(input string n, input fwd_res_s e);
        compares++;
        if (res !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, res);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release for a cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 64);
        q = rdat;
        if (n >= 64) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic load(input int r, input logic v, input logic [12:0] f, input logic [1:0] ag,
                        input logic [11:0] a);
        load_en <= 1'b1;
        load_row <= r[5:0];
        load_entry <= '{valid:v, mac:MAC_W'(r), fid:f, kind:2'b00, addr:a, age:ag,
                        learn_all:1'b0, skip_vlan:1'b0};
        @(posedge clk);
        load_en <= 1'b0;
        @(posedge clk);
    endtask

    // Starts a scan, pokes the config while busy (must be dropped), polls completion
    task automatic scan(input logic [5:0] r, input logic [31:0] cfg);
        int n;
        xfer(1'b1, OFS_SCAN_CFG, cfg);
        xfer(1'b1, OFS_ACCESS_CTRL, {18'h0_0000, r, 8'h15});
        xfer(1'b1, OFS_SCAN_CFG, 32'h0000_0000);
        n = 0;
        do begin
            xfer(1'b0, OFS_ACCESS_CTRL, 32'h0000_0000);
            n++;
        end while (q[TRIG_BIT] !== 1'b0 && n < 200);
        chk("trigger", 32'h0000_0000, {31'h0, q[TRIG_BIT]});
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(n, e, q);
    endtask

    task automatic look(input int m, input logic [12:0] e, input logic [15:0] vm,
                        input logic [15:0] sm);
        req <= '{valid:1'b1, dmac:MAC_W'(m), egress_filtering_identifier:e, vlan_mask:vm, src_mask:sm};
        // Result registered at the first edge is registered again unchanged at the second edge, then read
        repeat (2) @(posedge clk);
    endtask

    task automatic look_end;
        req.valid <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        rd_chk("ctrl reset", OFS_ACCESS_CTRL, 32'h0000_0000);
        rd_chk("pos reset", OFS_POS_STATUS, 32'h0000_0000);
        rd_chk("count reset", OFS_MATCH_CNT, 32'h0000_0000);
        rd_chk("events reset", OFS_EVENTS, 32'h0000_0000);
        xfer(1'b1, OFS_SCAN_CFG, 32'h0000_3301);
        rd_chk("scan cfg", OFS_SCAN_CFG, 32'h0000_3301);
        xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        for (int r = 0; r < ROWS; r++) load(r, 1'b0, 13'h0, 2'h0, 12'h0);
        $display("register test done");
    endtask

    task automatic test_remove;
        load(3, 1'b1, 13'h7, 2'h0, 12'h0);
        load(10, 1'b1, 13'h7, 2'h0, 12'h0);
        load(15, 1'b1, 13'h8, 2'h0, 12'h0);
        load(20, 1'b1, 13'h7, 2'h0, 12'h0);
        xfer(1'b1, OFS_ENTRY_CFG, 32'h0000_0007);
        scan(6'd0, 32'h0000_0280);
        rd_chk("count", OFS_MATCH_CNT, 32'h0000_0003);
        rd_chk("pos", OFS_POS_STATUS, 32'h0000_0014);
        rd_chk("events", OFS_EVENTS, 32'h0000_0003);
        xfer(1'b1, OFS_EVENTS, 32'h0000_0003);
        rd_chk("events clr", OFS_EVENTS, 32'h0000_0000);
        scan(6'd0, 32'h0000_0200);
        rd_chk("count after", OFS_MATCH_CNT, 32'h0000_0000);
        rd_chk("events none", OFS_EVENTS, 32'h0000_0000);
        $display("remove test done");
    endtask

    task automatic test_find;
        load(5, 1'b1, 13'h9, 2'h0, 12'h0);
        load(9, 1'b1, 13'h9, 2'h0, 12'h0);
        xfer(1'b1, OFS_ENTRY_CFG, 32'h0000_0009);
        scan(6'd0, 32'h0000_0201);
        rd_chk("first pos", OFS_POS_STATUS, 32'h0000_0005);
        rd_chk("first count", OFS_MATCH_CNT, 32'h0000_0001);
        scan(6'd6, 32'h0000_0201);
        rd_chk("next pos", OFS_POS_STATUS, 32'h0000_0009);
        scan(6'd10, 32'h0000_0201);
        rd_chk("end count", OFS_MATCH_CNT, 32'h0000_0000);
        $display("find next test done");
    endtask

    task automatic test_age;
        load(30, 1'b1, 13'hB, 2'h0, 12'h0);
        load(31, 1'b1, 13'hB, 2'h1, 12'h0);
        xfer(1'b1, OFS_ENTRY_CFG, 32'h0000_000B);
        xfer(1'b1, OFS_EVENTS, 32'h0000_0003);
        scan(6'd30, 32'h0000_020F);
        scan(6'd0, 32'h0000_3300);
        // Aging deletes without the removal event; that one belongs to the remove action
        rd_chk("age del", OFS_EVENTS, 32'h0000_0002);
        scan(6'd0, 32'h0000_0200);
        rd_chk("age kept", OFS_MATCH_CNT, 32'h0000_0001);
        xfer(1'b1, OFS_EVENTS, 32'h0000_0003);
        scan(6'd0, 32'h0000_3300);
        rd_chk("age inc", OFS_EVENTS, 32'h0000_0002);
        scan(6'd0, 32'h0000_3300);
        rd_chk("age max", OFS_EVENTS, 32'h0000_0002);
        scan(6'd0, 32'h0000_0200);
        rd_chk("age left", OFS_MATCH_CNT, 32'h0000_0000);
        $display("aging test done");
    endtask

    task automatic test_move_hit;
        load(40, 1'b1, 13'h4, 2'h0, 12'h012);
        pg_we <= 1'b1; pg_idx <= 6'h25; pg_mask <= 16'hAAAA;
        @(posedge clk);
        pg_idx <= 6'h12; pg_mask <= 16'h5555;
        @(posedge clk);
        pg_we <= 1'b0;
        xfer(1'b1, OFS_ENTRY_CFG, 32'h0012_0000);
        xfer(1'b1, OFS_MOVE_CFG, 32'h0FFF_0025);
        xfer(1'b1, OFS_FWD_CFG, 32'h0000_0000);
        scan(6'd0, 32'h0000_0440);
        rd_chk("move count", OFS_MATCH_CNT, 32'h0000_0001);
        look(40, 13'h4, 16'hFFFF, 16'hFFFF);
        chk_res("hit", '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 16'hAAAA});
        look(40, 13'h5, 16'hFFFF, 16'hFFFF);
        chk_res("egress_filtering_identifier miss", '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0000});
        look_end();
        $display("move and hit test done");
    endtask

    task automatic test_flood;
        pg_we <= 1'b1; pg_idx <= 6'h21; pg_mask <= 16'h0F0F;
        @(posedge clk);
        pg_we <= 1'b0;
        xfer(1'b1, OFS_FWD_CFG, 32'h0021_0513);
        look(153, 13'h1, 16'hFFFF, 16'hFFFF);
        chk_res("flood", '{1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 16'h0F0F});
        look(153, 13'h1, 16'h00FF, 16'hFFF0);
        chk_res("flood masked", '{1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 16'h0000});
        look_end();
        xfer(1'b1, OFS_FWD_CFG, 32'h0021_0517);
        look(153, 13'h1, 16'h00FF, 16'hFFF0);
        chk_res("skip vlan", '{1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 16'h0F00});
        look_end();
        xfer(1'b1, OFS_FWD_CFG, 32'h0021_051F);
        look(153, 13'h1, 16'h00FF, 16'hFFF0);
        chk_res("skip src", '{1'b1, 1'b1, 1'b1, 1'b1, 3'h5, 16'h000F});
        look_end();
        $display("flood test done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF;
        wdat = 32'h0000_0000; load_en = 1'b0; load_row = 6'h0; load_entry = '0;
        pg_we = 1'b0; pg_idx = 6'h0; pg_mask = 16'h0000; req = '0;
        fail_count = 0; compares = 0; cycles = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_remove();
        test_find();
        test_age();
        test_move_hit();
        test_flood();
        end_sim();
    end
endmodule
